/* hdl/usb_phy_irq_regs.sv */
// PHY override, pull-down trim and raw interrupt register slice
// Contract
// - Enabled override drives PHY from direct value, else from normal logic. The code ties unused bits 14:13 to 0.
// - Direct-value register holds software levels, used only where overridden.
// - Bits 12:8 trim code, reset 0x1f, drive minus-line pull-down.
// - Bits 4:0 trim code, reset 0x1f, drive plus-line pull-down.
// - Bit 19 is OR of endpoint halt-or-refuse flags.
// - Bit 18 is OR of endpoint abort-done flags.
// - Device role: bit 17 sets on frame start, clears on frame-number read.
// - Bit 15 sets on upstream resume, clears on engine resume write.
// - Bit 14 sets on sleep state change, clears on suspended write.
// - Bit 13 sets on attach change, clears on connected write.
// - Bit 4 is OR of endpoint buffer-done flags.
// - Bit 3 sets on transaction finished, clears on its write.
// - Host role: bit 2 sets on sent frame start, clears on frame-number read.
// - Host role: bit 1 sets on remote wake, clears on resume write.
// - Host role: bit 0 sets on speed change, clears on speed write.
`timescale 1ns/1ps
module usb_phy_irq_regs
  import usb_phy_irq_pkg::*;
(
  input  wire logic         clock_i,
  input  wire logic         reset_i,
  input  wire logic         ce_i,
  input  wire logic [7:0]   address_i,
  input  wire logic         read_i,
  input  wire logic         write_i,
  input  wire logic [31:0]  writedata_i,
  input  wire logic [3:0]   byteenable_i,
  output logic [31:0]       readdata_o,
  output logic              waitrequest_o,
  input  wire phy_ctrl_s    phy_normal_i,
  output phy_ctrl_s         phy_ctrl_o,
  output phy_trim_s         phy_trim_o,
  input  wire ctrl_events_s events_i,
  input  wire ctrl_clears_s clears_i,
  output logic              irq_o
);
  // ===========================================
  // Bus slave: one wait cycle per access
  logic        ack_q;
  logic        req;
  logic        commit;
  logic [31:0] be_bits;
  assign req           = read_i | write_i;
  assign commit        = req & ack_q & ce_i;
  assign waitrequest_o = req & ~(ack_q & ce_i);
  assign be_bits       = {{8{byteenable_i[3]}}, {8{byteenable_i[2]}},
                          {8{byteenable_i[1]}}, {8{byteenable_i[0]}}};

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      ack_q <= 1'b0;
    else if (ce_i)
      ack_q <= req & ~ack_q;
  end

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [31:0] keep);
    merge = ((old_v & ~keep) | (new_v & keep));
  endfunction

  logic wr_direct;
  logic wr_ovr;
  logic wr_trim;
  logic wr_stat;
  logic wr_mask;
  assign wr_direct = commit & write_i & (address_i == OFS_DIRECT);
  assign wr_ovr    = commit & write_i & (address_i == OFS_OVERRIDE);
  assign wr_trim   = commit & write_i & (address_i == OFS_TRIM);
  assign wr_stat   = commit & write_i & (address_i == OFS_IRQ_STAT);
  assign wr_mask   = commit & write_i & (address_i == OFS_IRQ_MASK);

  // ===========================================
  // Software registers
  logic [31:0] direct_q;
  logic [31:0] ovr_q;
  logic [31:0] trim_q;

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      direct_q <= DIRECT_RST;
      ovr_q    <= OVERRIDE_RST;
      trim_q   <= {19'h0_0000, TRIM_RST, 3'h0, TRIM_RST};
    end
    else if (ce_i)
    begin
      if (wr_direct)
        direct_q <= merge(direct_q, writedata_i, be_bits & DIRECT_WMASK);
      if (wr_ovr)
        ovr_q <= merge(ovr_q, writedata_i, be_bits & OVERRIDE_WMASK);
      if (wr_trim)
        trim_q <= merge(trim_q, writedata_i, be_bits & TRIM_WMASK);
    end
  end

  // ===========================================
  // PHY control selection
  logic [15:0] normal_v;
  logic [15:0] phy_d;
  logic [15:0] phy_q;
  assign normal_v = phy_normal_i;

  for (genvar i = 0; i < 16; i++)
  begin : g_sel
    if (OVERRIDE_WMASK[i])
    begin : g_used
      assign phy_d[i] = ovr_q[i] ? direct_q[DIRECT_BIT[i]] : normal_v[i];
    end
    else
    begin : g_none
      assign phy_d[i] = 1'b0;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      phy_q <= 16'h0000;
    else if (ce_i)
      phy_q <= phy_d;
  end
  assign phy_ctrl_o = phy_q;
  assign phy_trim_o.minus_line_pulldown_code = trim_q[TRIM_MINUS_LSB +: 5];
  assign phy_trim_o.plus_line_pulldown_code  = trim_q[TRIM_PLUS_LSB +: 5];

  // ===========================================
  // Raw interrupt register
  logic        sleep_q;
  logic        attach_q;
  logic [1:0]  speed_q;
  logic [31:0] sticky_set;
  logic [31:0] sticky_clr;
  logic [31:0] sticky_q;
  logic [31:0] raw;
  logic        host;
  assign host = events_i.host_role;

  always_comb
  begin
    sticky_set = 32'h0000_0000;
    sticky_clr = 32'h0000_0000;
    sticky_set[RB_SOF_DEV]     = events_i.frame_start_rx & ~host;
    sticky_set[RB_WAKE_UP]     = events_i.wake_from_upstream;
    sticky_set[RB_SLEEP]       = events_i.sleep_state != sleep_q;
    sticky_set[RB_ATTACH]      = events_i.attach_state != attach_q;
    sticky_set[RB_TXN_DONE]    = events_i.transaction_finished;
    sticky_set[RB_SOF_HOST]    = events_i.frame_start_tx & host;
    sticky_set[RB_REMOTE_WAKE] = events_i.remote_wake & host;
    sticky_set[RB_DS_ATTACH]   = host & (events_i.speed != speed_q);
    sticky_clr[RB_SOF_DEV]     = clears_i.frame_num_read;
    sticky_clr[RB_WAKE_UP]     = clears_i.resume_write;
    sticky_clr[RB_SLEEP]       = clears_i.suspended_write;
    sticky_clr[RB_ATTACH]      = clears_i.connected_write;
    sticky_clr[RB_TXN_DONE]    = clears_i.txn_done_write;
    sticky_clr[RB_SOF_HOST]    = clears_i.frame_num_read;
    sticky_clr[RB_REMOTE_WAKE] = clears_i.resume_write;
    sticky_clr[RB_DS_ATTACH]   = clears_i.speed_write;
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      sticky_q <= 32'h0000_0000;
      sleep_q  <= 1'b0;
      attach_q <= 1'b0;
      speed_q  <= 2'h0;
    end
    else if (ce_i)
    begin
      // Set wins over a clear in the same cycle
      sticky_q <= ((sticky_q & ~sticky_clr) | sticky_set) & STICKY_MASK;
      sleep_q  <= events_i.sleep_state;
      attach_q <= events_i.attach_state;
      speed_q  <= events_i.speed;
    end
  end

  always_comb
  begin
    raw = sticky_q & STICKY_MASK;
    raw[RB_HALT_REFUSE] = |events_i.endpoint_halt_refuse_flags;
    raw[RB_ABORT]       = |events_i.abort_done_flags;
    raw[RB_SETUP]       = events_i.engine_flags[8];
    raw[12:RB_ENG_LSB]  = events_i.engine_flags[7:0];
    raw[RB_BUF_DONE]    = |events_i.buffer_done_flags;
    raw = raw & RAW_WMASK;
  end

  // ===========================================
  // Interrupt status, mask and output
  logic [31:0] raw_q;
  logic [31:0] stat_q;
  logic [31:0] mask_q;
  logic [31:0] rise;
  assign rise = raw & ~raw_q;

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      raw_q  <= 32'h0000_0000;
      stat_q <= 32'h0000_0000;
      mask_q <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      raw_q <= raw;
      if (wr_stat)
        stat_q <= (stat_q & ~(writedata_i & be_bits)) | rise;
      else
        stat_q <= stat_q | rise;
      if (wr_mask)
        mask_q <= merge(mask_q, writedata_i, be_bits & RAW_WMASK);
    end
  end
  assign irq_o = |(stat_q & mask_q);

  // ===========================================
  // Read data, registered in the wait cycle
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  always_comb
  begin
    case (address_i)
      OFS_DIRECT:   rdata_d = direct_q;
      OFS_OVERRIDE: rdata_d = ovr_q;
      OFS_TRIM:     rdata_d = trim_q;
      OFS_RAW:      rdata_d = raw;
      OFS_IRQ_STAT: rdata_d = stat_q;
      OFS_IRQ_MASK: rdata_d = mask_q;
      default:      rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      rdata_q <= 32'h0000_0000;
    else if (ce_i & read_i & ~ack_q)
      rdata_q <= rdata_d;
  end
  assign readdata_o = rdata_q;

  // ===========================================
  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  a_ovr_direct_pass: assert property (
    ce_i && ovr_q[7] |=> phy_q[7] == $past(direct_q[10]))
    else $error("override tx_dp not taken from direct value");
  a_ovr_normal_pass: assert property (
    ce_i && !ovr_q[3] |=> phy_q[3] == $past(normal_v[3]))
    else $error("normal pull-down not passed through");
  a_direct_ro_zero: assert property (
    (direct_q & ~DIRECT_WMASK) == 32'h0000_0000)
    else $error("direct value read-only bits set");
  a_trim_minus_code: assert property (
    wr_trim && byteenable_i[1] |=>
      phy_trim_o.minus_line_pulldown_code == $past(writedata_i[12:8]))
    else $error("minus-line trim not driven");
  a_trim_plus_code: assert property (
    wr_trim && byteenable_i[0] |=>
      phy_trim_o.plus_line_pulldown_code == $past(writedata_i[4:0]))
    else $error("plus-line trim not driven");
  a_trim_hold: assert property (
    !wr_trim |=> trim_q == $past(trim_q))
    else $error("trim changed without write");
  a_halt_refuse_or: assert property (
    raw[RB_HALT_REFUSE] == (events_i.endpoint_halt_refuse_flags != 32'h0))
    else $error("halt summary mismatch");
  a_abort_done_or: assert property (
    raw[RB_ABORT] == (events_i.abort_done_flags != 32'h0))
    else $error("abort summary mismatch");
  a_sof_dev_set: assert property (
    ce_i && events_i.frame_start_rx && !host |=> raw[RB_SOF_DEV])
    else $error("device frame start lost");
  a_sof_dev_clear: assert property (
    ce_i && clears_i.frame_num_read && !sticky_set[RB_SOF_DEV] |=> !sticky_q[RB_SOF_DEV])
    else $error("frame read did not clear");
  a_wake_up_set: assert property (
    ce_i && events_i.wake_from_upstream |=> raw[RB_WAKE_UP])
    else $error("upstream resume lost");
  a_sleep_set: assert property (
    ce_i && (events_i.sleep_state != sleep_q) |=> raw[RB_SLEEP])
    else $error("sleep change lost");
  a_attach_set: assert property (
    ce_i && (events_i.attach_state != attach_q) |=> raw[RB_ATTACH])
    else $error("attach change lost");
  a_buf_done_or: assert property (
    raw[RB_BUF_DONE] == (events_i.buffer_done_flags != 32'h0))
    else $error("buffer summary mismatch");
  a_txn_hold_until: assert property (
    ce_i && sticky_q[RB_TXN_DONE] && !clears_i.txn_done_write |=> sticky_q[RB_TXN_DONE])
    else $error("transaction bit dropped without write");
  a_txn_clear: assert property (
    ce_i && clears_i.txn_done_write && !events_i.transaction_finished
      |=> !raw[RB_TXN_DONE])
    else $error("transaction write did not clear");
  a_host_sof_gate: assert property (
    ce_i && !host && !sticky_q[RB_SOF_HOST] |=> !sticky_q[RB_SOF_HOST])
    else $error("host frame bit set in device role");
  a_remote_wake_set: assert property (
    ce_i && host && events_i.remote_wake |=> raw[RB_REMOTE_WAKE])
    else $error("remote wake lost");
  a_speed_change_set: assert property (
    ce_i && host && (events_i.speed != speed_q) |=> raw[RB_DS_ATTACH])
    else $error("speed change lost");
  a_engine_mirror: assert property (
    raw[12:RB_ENG_LSB] == events_i.engine_flags[7:0]
      && raw[RB_SETUP] == events_i.engine_flags[8])
    else $error("engine flags not mirrored");
  a_raw_upper_zero: assert property (
    raw[31:20] == 12'h000)
    else $error("raw reserved bits not zero");
  a_irq_level: assert property (
    !irq_o ##1 irq_o |-> $past(((rise & mask_q) != 32'h0) || wr_mask))
    else $error("interrupt raised without cause");
  a_ce_freeze: assert property (
    !ce_i |=> phy_q == $past(phy_q) && sticky_q == $past(sticky_q))
    else $error("state moved with clock enable low");
  a_wait_one: assert property (
    req && !ack_q && ce_i |=> !waitrequest_o || !req || !ce_i)
    else $error("wait longer than one cycle");

  c_override_used: cover property (wr_ovr ##1 ovr_q != 32'h0);
  c_sof_cleared: cover property (sticky_q[RB_SOF_DEV] ##1 !sticky_q[RB_SOF_DEV]);
  c_irq_raised: cover property (!irq_o ##1 irq_o);
  c_read_raw: cover property (commit && read_i && address_i == OFS_RAW);
  c_ce_stall: cover property (req && !ce_i ##1 req && ce_i);
endmodule

/* hdl/usb_phy_irq_pkg.sv */
// Shared constants and carriers of the PHY override and raw interrupt slice
package usb_phy_irq_pkg;
  // ===========================================
  // Register byte offsets
  localparam logic [7:0] OFS_DIRECT   = 8'h7c;
  localparam logic [7:0] OFS_OVERRIDE = 8'h80;
  localparam logic [7:0] OFS_TRIM     = 8'h84;
  localparam logic [7:0] OFS_RAW      = 8'h8c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'ha0;
  localparam logic [7:0] OFS_IRQ_MASK = 8'ha4;
  // ===========================================
  // Field layouts and reset values
  localparam logic [31:0] DIRECT_WMASK   = 32'h0000_ff77;
  localparam logic [31:0] OVERRIDE_WMASK = 32'h0000_9fff;
  localparam logic [31:0] TRIM_WMASK     = 32'h0000_1f1f;
  localparam logic [31:0] RAW_WMASK      = 32'h000f_ffff;
  localparam logic [31:0] STICKY_MASK    = 32'h0002_e00f;
  localparam logic [31:0] OVERRIDE_RST   = 32'h0000_0000;
  localparam logic [31:0] DIRECT_RST     = 32'h0000_0000;
  localparam logic [4:0]  TRIM_RST       = 5'h1f;
  localparam int TRIM_MINUS_LSB = 8;
  localparam int TRIM_PLUS_LSB  = 0;
  // Raw interrupt bit positions
  localparam int RB_HALT_REFUSE = 19;
  localparam int RB_ABORT       = 18;
  localparam int RB_SOF_DEV     = 17;
  localparam int RB_SETUP       = 16;
  localparam int RB_WAKE_UP     = 15;
  localparam int RB_SLEEP       = 14;
  localparam int RB_ATTACH      = 13;
  localparam int RB_ENG_LSB     = 5;
  localparam int RB_BUF_DONE    = 4;
  localparam int RB_TXN_DONE    = 3;
  localparam int RB_SOF_HOST    = 2;
  localparam int RB_REMOTE_WAKE = 1;
  localparam int RB_DS_ATTACH   = 0;
  // Override bit i selects this bit of the direct-value register
  localparam int DIRECT_BIT [16] = '{0, 4, 1, 2, 6, 8, 9, 10, 11, 12, 13, 14, 5, 0, 0, 15};
  // ===========================================
  // Carriers
  typedef struct packed {
    logic transmit_differential_select;
    logic [1:0] unused;
    logic dm_pullup_en;
    logic tx_fsslew;
    logic tx_pd;
    logic rx_pd;
    logic tx_dm;
    logic tx_dp;
    logic tx_dm_oe;
    logic tx_dp_oe;
    logic dm_pulldn_en;
    logic dp_pulldn_en;
    logic dp_pullup_en;
    logic dm_pullup_hisel;
    logic dp_pullup_hisel;
  } phy_ctrl_s;
  typedef struct packed {
    logic [4:0] minus_line_pulldown_code;
    logic [4:0] plus_line_pulldown_code;
  } phy_trim_s;
  typedef struct packed {
    logic        host_role;
    logic [31:0] endpoint_halt_refuse_flags;
    logic [31:0] abort_done_flags;
    logic [31:0] buffer_done_flags;
    logic        frame_start_rx;
    logic        frame_start_tx;
    logic        wake_from_upstream;
    logic        remote_wake;
    logic        sleep_state;
    logic        attach_state;
    logic [1:0]  speed;
    logic        transaction_finished;
    logic [8:0]  engine_flags;
  } ctrl_events_s;
  typedef struct packed {
    logic frame_num_read;
    logic resume_write;
    logic suspended_write;
    logic connected_write;
    logic txn_done_write;
    logic speed_write;
  } ctrl_clears_s;
endpackage

/* testbench/phy_side_model.sv */
// Transceiver-side model giving the controller's own PHY levels
`timescale 1ns/1ps
module phy_side_model
  import usb_phy_irq_pkg::*;
(
  input  wire logic      clock_i,
  input  wire logic      reset_i,
  input  wire phy_ctrl_s phy_ctrl_i,
  input  wire phy_trim_s phy_trim_i,
  output phy_ctrl_s      phy_normal_o
);
  // ===========================================
  // Normal levels change every cycle, so a stale copy never passes
  logic [15:0] lfsr_q;
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      lfsr_q <= 16'hace1;
    else
      lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
  end
  assign phy_normal_o = lfsr_q;
endmodule

/* testbench/usb_phy_override_and_raw_irq_bench.sv */
// Self-checking bench of the PHY override, trim and raw interrupt slice
`timescale 1ns/1ps
module usb_phy_override_and_raw_irq_bench
  import usb_phy_irq_pkg::*;
();
  // ===========================================
  // Signals
  logic         clock = 1'b0;
  logic         reset = 1'b1;
  logic         ce = 1'b1;
  logic [7:0]   address = 8'h00;
  logic         rd = 1'b0;
  logic         wr = 1'b0;
  logic [31:0]  wdata = 32'h0000_0000;
  logic [31:0]  rdata;
  logic         waitreq;
  logic         irq;
  phy_ctrl_s    normal;
  phy_ctrl_s    ctrl;
  phy_trim_s    trim;
  ctrl_events_s ev = '0;
  ctrl_events_s pv = '0;
  ctrl_events_s pe;
  ctrl_clears_s cl = '0;
  ctrl_clears_s pc;
  logic [15:0]  prev_n = 16'h0000;
  logic [31:0]  expq [$];
  logic [31:0]  ovr;
  logic [31:0]  dir;
  logic [31:0]  tv;
  logic [31:0]  e;
  int           n_fail = 0;
  int           checked = 0;
  int           cycles = 0;

  always #4 clock = ~clock;

  usb_phy_irq_regs dut (
    .clock_i(clock), .reset_i(reset), .ce_i(ce), .address_i(address),
    .read_i(rd), .write_i(wr), .writedata_i(wdata), .byteenable_i(4'hf),
    .readdata_o(rdata), .waitrequest_o(waitreq), .phy_normal_i(normal),
    .phy_ctrl_o(ctrl), .phy_trim_o(trim), .events_i(ev | pv), .clears_i(cl),
    .irq_o(irq)
  );

  phy_side_model model (
    .clock_i(clock), .reset_i(reset), .phy_ctrl_i(ctrl), .phy_trim_i(trim),
    .phy_normal_o(normal)
  );

  // ===========================================
  // Compare, verdict and bus tasks
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checked++;
    if (got !== ex)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task conclude;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    rd <= ~w;
    wr <= w;
    address <= a;
    wdata <= d;
    @(posedge clock);
    while (waitreq !== 1'b0) @(posedge clock);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task rreg(input logic [7:0] a, input logic [31:0] ex);
    expq.push_back(ex);
    bus(1'b0, a, 32'h0000_0000);
  endtask

  task pul(input ctrl_events_s p, input ctrl_clears_s c);
    @(posedge clock);
    pv <= p;
    cl <= c;
    @(posedge clock);
    pv <= '0;
    cl <= '0;
  endtask

  // ===========================================
  // Read monitor, normal-level history and timeout
  always @(posedge clock)
  begin
    prev_n <= normal;
    cycles <= cycles + 1;
    if (rd === 1'b1 && waitreq === 1'b0 && expq.size() > 0)
      chk("readdata", expq.pop_front(), rdata);
    if (cycles == 5000)
    begin
      n_fail++;
      conclude();
    end
  end

  // ===========================================
  // Main sequence
  initial
  begin
    void'($urandom(32'hc87c));
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    @(negedge clock);
    chk("trim out", 32'h0000_03ff, 32'(trim));
    rreg(OFS_OVERRIDE, 32'h0000_0000);
    rreg(OFS_TRIM, 32'h0000_1f1f);
    rreg(OFS_RAW, 32'h0000_0000);
    $display("reset values done");
    tv = $urandom & TRIM_WMASK;
    bus(1'b1, OFS_TRIM, tv | 32'hffff_e0e0);
    rreg(OFS_TRIM, tv);
    chk("trim out", {22'h0, tv[12:8], tv[4:0]}, 32'(trim));
    $display("trim done");
    repeat (4)
    begin
      dir = $urandom & DIRECT_WMASK;
      ovr = $urandom & OVERRIDE_WMASK;
      bus(1'b1, OFS_DIRECT, dir);
      bus(1'b1, OFS_OVERRIDE, ovr);
      rreg(OFS_OVERRIDE, ovr);
      rreg(OFS_DIRECT, dir);
      repeat (6)
      begin
        @(negedge clock);
        e = 32'h0000_0000;
        for (int i = 0; i < 16; i++) e[i] = ovr[i] ? dir[DIRECT_BIT[i]] : prev_n[i];
        e[14:13] = 2'b00;
        chk("phy ctrl", e, 32'(ctrl));
      end
    end
    $display("override done");
    ev.sleep_state <= 1'b1;
    ev.attach_state <= 1'b1;
    ev.engine_flags <= 9'h1ff;
    ev.endpoint_halt_refuse_flags <= $urandom | 32'h0000_0001;
    ev.abort_done_flags <= 32'h8000_0000;
    ev.buffer_done_flags <= $urandom | 32'h0000_0001;
    pe = '0;
    pe.frame_start_rx = 1'b1;
    pe.frame_start_tx = 1'b1;
    pe.wake_from_upstream = 1'b1;
    pe.remote_wake = 1'b1;
    pe.transaction_finished = 1'b1;
    pul(pe, '0);
    rreg(OFS_RAW, 32'h000f_fff8);
    ev.endpoint_halt_refuse_flags <= 32'h0000_0001;
    ev.abort_done_flags <= 32'h0000_0000;
    ev.buffer_done_flags <= 32'h0000_0000;
    ev.engine_flags <= 9'h000;
    pc = '1;
    pul('0, pc);
    rreg(OFS_RAW, 32'h0008_0000);
    ev.endpoint_halt_refuse_flags <= 32'h0000_0000;
    rreg(OFS_RAW, 32'h0000_0000);
    $display("device events done");
    ev.host_role <= 1'b1;
    @(posedge clock);
    ev.speed <= 2'b01;
    pul(pe, '0);
    rreg(OFS_RAW, 32'h0000_800f);
    pc = '0;
    pc.frame_num_read = 1'b1;
    pc.resume_write = 1'b1;
    pc.speed_write = 1'b1;
    pc.txn_done_write = 1'b1;
    pul('0, pc);
    bus(1'b1, OFS_RAW, 32'hffff_ffff);
    rreg(OFS_RAW, 32'h0000_0000);
    $display("host events done");
    bus(1'b1, OFS_IRQ_STAT, 32'hffff_ffff);
    rreg(OFS_IRQ_STAT, 32'h0000_0000);
    bus(1'b1, OFS_IRQ_MASK, 32'h0000_0008);
    rreg(OFS_IRQ_MASK, 32'h0000_0008);
    chk("irq", 32'h0000_0000, {31'h0, irq});
    pe = '0;
    pe.transaction_finished = 1'b1;
    pul(pe, '0);
    @(posedge clock);
    @(negedge clock);
    chk("irq", 32'h0000_0001, {31'h0, irq});
    rreg(OFS_IRQ_STAT, 32'h0000_0008);
    pc = '0;
    pc.txn_done_write = 1'b1;
    pul('0, pc);
    bus(1'b1, OFS_IRQ_STAT, 32'h0000_0008);
    @(negedge clock);
    chk("irq", 32'h0000_0000, {31'h0, irq});
    ce <= 1'b0;
    fork
      rreg(OFS_TRIM, tv);
      begin
        @(negedge clock);
        e = 32'(ctrl);
        repeat (3) @(posedge clock);
        chk("frozen ctrl", e, 32'(ctrl));
        ce <= 1'b1;
      end
    join
    $display("clock enable done");
    rreg(8'hf0, 32'h0000_0000);
    $display("interrupt done");
    conclude();
  end
endmodule
